// File: hw/bcfh_core.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - transmit only as reply to received command
// - transceiver drives only while replying
// - execute fully before reply starts
// - core command is seven bytes, msb first
// - serial frame: address, seven bytes, checksum
// - checksum is 8-bit sum including address
// - exactly one reply per host command
// - serial reply nine bytes in fixed order
// - reply checksum sums all other bytes
// - CAN frame drops address and checksum
// - CAN reply drops both, id carries address
// - status 100 executed, 101 stored
// - error codes one through six
// - store program, run it without host
module bcfh_core
  import bcfh_pkg::*;
#(
  parameter int PROG_DEPTH = 64, // stored commands
  parameter int PTR_W      = 6   // log2 of PROG_DEPTH
)
(
  input  wire logic        clk_in,         // 50 MHz clock
  input  wire logic        rst_n_in,       // sync reset, low
  input  wire logic        can_mode_in,    // 1: CAN framing
  input  wire logic [7:0]  module_addr_in, // own address
  input  wire logic [7:0]  reply_addr_in,  // reply address / CAN id
  input  wire logic        load_mode_in,   // 1: store, not execute
  input  wire logic        prog_clear_in,  // empty program memory
  input  wire logic        run_start_in,   // start stored program
  input  wire logic [7:0]  rx_data_in,     // received byte
  input  wire logic        rx_valid_in,    // byte strobe
  output logic             exec_req_out,   // command at executor
  output logic      [7:0]  exec_cmd_out,   // command number
  output logic      [7:0]  exec_type_out,  // type number
  output logic      [7:0]  exec_bank_out,  // motor or bank
  output logic      [31:0] exec_value_out, // value
  output logic             exec_host_out,  // 1 host, 0 standalone
  input  wire logic        exec_done_in,   // executor finished
  input  wire logic [7:0]  exec_status_in, // 100 or error code
  input  wire logic [31:0] exec_value_in,  // reply value
  output logic      [7:0]  tx_data_out,    // reply byte
  output logic             tx_valid_out,   // reply byte valid
  output logic             tx_last_out,    // final reply byte
  input  wire logic        tx_ready_in,    // link takes byte
  output logic             xcvr_tx_n_out,  // low: drive the bus
  output logic      [7:0]  can_id_out,     // CAN reply identifier
  output logic      [PTR_W:0] prog_len_out, // stored commands
  output logic             run_busy_out    // standalone running
);

  // ****************************************************************
  // assertion defaults
  // ****************************************************************
  default clocking bcfh_cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  bcfh_state_t       state_q;    // frame handler state
  logic [3:0]        rx_idx_q;   // bytes taken this frame
  logic              addr_ok_q;  // address byte matched
  logic [7:0]        cmd_q;      // received command
  logic [7:0]        type_q;     // received type
  logic [7:0]        bank_q;     // received bank
  logic [31:0]       val_q;      // received value
  logic [3:0]        rx_pos;     // serial position of byte
  logic [31:0]       full_val;   // value incl. current byte
  logic [7:0]        rx_acc;     // sum of bytes before this
  logic              rx_take;    // byte accepted
  logic              frame_end;  // last frame byte now
  logic              addr_ok;    // frame is for us
  logic              csum_ok;    // checksum matched
  logic              run_go;     // start standalone run
  logic              exec_fin;   // executor done in EXEC
  logic              exec_req_q; // request level
  logic              host_q;     // request from host
  logic [7:0]        ecmd_q;     // command at executor
  logic [7:0]        etype_q;    // type at executor
  logic [7:0]        ebank_q;    // bank at executor
  logic [31:0]       evalue_q;   // value at executor
  logic [55:0]       prog_mem [PROG_DEPTH]; // program store
  logic [PTR_W:0]    prog_len_q; // stored count
  logic [PTR_W-1:0]  run_ptr_q;  // next stored command
  logic [PTR_W:0]    ptr_nx;     // pointer plus one
  logic              prog_full;  // no room left
  logic              run_last;   // final stored command
  logic              go_tx;      // reply starts
  logic [7:0]        stat_d;     // status for reply
  logic [31:0]       rval_d;     // value for reply
  logic [7:0]        stat_q;     // held reply status
  logic [31:0]       rval_q;     // held reply value
  logic [3:0]        tx_pos_q;   // position of tx_data_q
  logic [7:0]        tx_data_q;  // byte on the link
  logic              drv_n_q;    // transceiver direction
  logic [7:0]        can_id_q;   // CAN reply id
  logic [7:0]        tx_acc;     // sum of sent bytes
  logic [7:0]        tx_next;    // sum incl. current byte
  logic              tx_fire;    // byte handed over
  logic              tx_is_last; // current byte is final

  // ****************************************************************
  // receive path
  // ****************************************************************
  // CAN frames start at the command byte, so shift numbering by one
  assign rx_pos    = can_mode_in ? rx_idx_q + 4'h1 : rx_idx_q;
  assign full_val  = (rx_pos == BCFH_POS_VAL3) ?
                     {val_q[23:0], rx_data_in} : val_q;
  // bytes outside IDLE are dropped: master must wait for the reply
  assign rx_take   = rx_valid_in && (state_q == BCFH_IDLE);
  assign frame_end = rx_take && (can_mode_in ?
                     (rx_pos == BCFH_POS_VAL3) :
                     (rx_pos == BCFH_POS_CSUM));
  assign addr_ok   = can_mode_in || addr_ok_q;
  assign csum_ok   = can_mode_in || (rx_data_in == rx_acc);

  // capture frame fields by position
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      rx_idx_q  <= 4'h0;
      addr_ok_q <= 1'b0;
      cmd_q     <= BCFH_RST_BYTE;
      type_q    <= BCFH_RST_BYTE;
      bank_q    <= BCFH_RST_BYTE;
      val_q     <= BCFH_RST_WORD;
    end
    else if (rx_take)
    begin
      rx_idx_q <= frame_end ? 4'h0 : rx_idx_q + 4'h1;
      case (rx_pos)
        BCFH_POS_ADDR: addr_ok_q <= (rx_data_in == module_addr_in);
        BCFH_POS_CMD:  cmd_q     <= rx_data_in;
        BCFH_POS_TYPE: type_q    <= rx_data_in;
        BCFH_POS_BANK: bank_q    <= rx_data_in;
        // value arrives msb first, shift left
        default:
          if (rx_pos != BCFH_POS_CSUM)
            val_q <= {val_q[23:0], rx_data_in};
      endcase
    end
  end

  bcfh_sum u_rx_sum (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .clear_in (frame_end),
    .add_in   (rx_take),
    .byte_in  (rx_data_in),
    .acc_out  (rx_acc),
    .next_out ()
  );

  // ****************************************************************
  // sequencing
  // ****************************************************************
  // standalone start waits for a quiet link so no byte is lost
  assign run_go   = (state_q == BCFH_IDLE) && run_start_in &&
                    !rx_valid_in && (rx_idx_q == 4'h0) &&
                    (prog_len_q != '0);
  assign exec_fin = (state_q == BCFH_EXEC) && exec_done_in;

  // main state machine
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      state_q <= BCFH_IDLE;
    else
      case (state_q)
        BCFH_IDLE:
          if (frame_end && addr_ok)
          begin
            if (!csum_ok)
              state_q <= BCFH_TX;
            else if (load_mode_in)
              state_q <= BCFH_STORE;
            else
              state_q <= BCFH_EXEC;
          end
          else if (run_go)
            state_q <= BCFH_EXEC;
        // reply only once the executor reports done
        BCFH_EXEC:
          if (exec_done_in)
            state_q <= host_q ? BCFH_TX :
                       (run_last ? BCFH_IDLE : BCFH_RUN);
        BCFH_RUN:   state_q <= BCFH_EXEC;
        BCFH_STORE: state_q <= BCFH_TX;
        BCFH_TX:
          if (tx_fire && tx_is_last)
            state_q <= BCFH_IDLE;
        default:    state_q <= BCFH_IDLE;
      endcase
  end

  // executor request and fields
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      exec_req_q <= 1'b0;
      host_q     <= 1'b0;
      ecmd_q     <= BCFH_RST_BYTE;
      etype_q    <= BCFH_RST_BYTE;
      ebank_q    <= BCFH_RST_BYTE;
      evalue_q   <= BCFH_RST_WORD;
    end
    else if ((state_q == BCFH_IDLE) && frame_end && addr_ok)
    begin
      // a corrupt frame is echoed but never executed
      exec_req_q <= csum_ok && !load_mode_in;
      host_q     <= 1'b1;
      ecmd_q     <= cmd_q;
      etype_q    <= type_q;
      ebank_q    <= bank_q;
      evalue_q   <= full_val;
    end
    else if (run_go || (state_q == BCFH_RUN))
    begin
      exec_req_q <= 1'b1;
      host_q     <= 1'b0;
      {ecmd_q, etype_q, ebank_q, evalue_q} <= prog_mem[run_ptr_q];
    end
    else if (exec_fin)
      exec_req_q <= 1'b0;
  end

  // ****************************************************************
  // program memory
  // ****************************************************************
  assign ptr_nx    = {1'b0, run_ptr_q} + {{PTR_W{1'b0}}, 1'b1};
  assign run_last  = (ptr_nx == prog_len_q);
  assign prog_full = (prog_len_q == (PTR_W+1)'(PROG_DEPTH));

  // store array, no reset needed
  always_ff @(posedge clk_in)
  begin
    if ((state_q == BCFH_STORE) && !prog_full)
      prog_mem[prog_len_q[PTR_W-1:0]] <=
        {ecmd_q, etype_q, ebank_q, evalue_q};
  end

  // fill level and run pointer
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      prog_len_q <= '0;
      run_ptr_q  <= '0;
    end
    else
    begin
      if (prog_clear_in && (state_q == BCFH_IDLE))
        prog_len_q <= '0;
      else if ((state_q == BCFH_STORE) && !prog_full)
        prog_len_q <= prog_len_q + {{PTR_W{1'b0}}, 1'b1};
      if (exec_fin && !host_q)
        run_ptr_q <= run_last ? '0 : ptr_nx[PTR_W-1:0];
    end
  end

  // ****************************************************************
  // reply path
  // ****************************************************************
  // pick status and value of the reply being started
  always_comb
  begin
    go_tx  = 1'b0;
    stat_d = stat_q;
    rval_d = rval_q;
    if ((state_q == BCFH_IDLE) && frame_end && addr_ok && !csum_ok)
    begin
      go_tx  = 1'b1;
      stat_d = BCFH_ST_CSUM;
      rval_d = BCFH_RST_WORD;
    end
    else if (state_q == BCFH_STORE)
    begin
      go_tx  = 1'b1;
      // a full store is refused as a bad value
      stat_d = prog_full ? BCFH_ST_BADVAL : BCFH_ST_LOADED;
      rval_d = evalue_q;
    end
    else if (exec_fin && host_q)
    begin
      go_tx  = 1'b1;
      stat_d = exec_status_in;
      rval_d = exec_value_in;
    end
  end

  // reply byte at a given serial position
  function automatic logic [7:0] reply_byte(input logic [3:0] pos);
    case (pos)
      BCFH_RPOS_RADDR: reply_byte = reply_addr_in;
      BCFH_RPOS_MADDR: reply_byte = module_addr_in;
      BCFH_RPOS_STAT:  reply_byte = stat_q;
      BCFH_RPOS_CMD:   reply_byte = ecmd_q;
      BCFH_RPOS_VAL0:  reply_byte = rval_q[31:24];
      BCFH_RPOS_VAL1:  reply_byte = rval_q[23:16];
      BCFH_RPOS_VAL2:  reply_byte = rval_q[15:8];
      BCFH_RPOS_VAL3:  reply_byte = rval_q[7:0];
      default:         reply_byte = BCFH_RST_BYTE;
    endcase
  endfunction

  assign tx_valid_out = (state_q == BCFH_TX);
  assign tx_fire      = tx_valid_out && tx_ready_in;
  assign tx_is_last   = can_mode_in ? (tx_pos_q == BCFH_RPOS_VAL3) :
                        (tx_pos_q == BCFH_RPOS_CSUM);
  assign tx_last_out  = tx_valid_out && tx_is_last;

  // reply byte sequencer
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      stat_q    <= BCFH_RST_BYTE;
      rval_q    <= BCFH_RST_WORD;
      tx_pos_q  <= 4'h0;
      tx_data_q <= BCFH_RST_BYTE;
      drv_n_q   <= 1'b1;
      can_id_q  <= BCFH_RST_BYTE;
    end
    else if (go_tx)
    begin
      stat_q   <= stat_d;
      rval_q   <= rval_d;
      can_id_q <= reply_addr_in;
      drv_n_q  <= 1'b0;
      // CAN reply starts at status, serial at reply address
      tx_pos_q  <= can_mode_in ? BCFH_RPOS_STAT : BCFH_RPOS_RADDR;
      tx_data_q <= can_mode_in ? stat_d : reply_addr_in;
    end
    else if (tx_fire)
    begin
      if (tx_is_last)
        drv_n_q <= 1'b1;
      else
      begin
        tx_pos_q <= tx_pos_q + 4'h1;
        if (tx_pos_q == BCFH_RPOS_VAL3)
          tx_data_q <= tx_next;
        else
          tx_data_q <= reply_byte(tx_pos_q + 4'h1);
      end
    end
  end

  bcfh_sum u_tx_sum (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .clear_in (go_tx),
    .add_in   (tx_fire),
    .byte_in  (tx_data_q),
    .acc_out  (tx_acc),
    .next_out (tx_next)
  );

  assign exec_req_out   = exec_req_q;
  assign exec_cmd_out   = ecmd_q;
  assign exec_type_out  = etype_q;
  assign exec_bank_out  = ebank_q;
  assign exec_value_out = evalue_q;
  assign exec_host_out  = host_q;
  assign tx_data_out    = tx_data_q;
  assign xcvr_tx_n_out  = drv_n_q;
  assign can_id_out     = can_id_q;
  assign prog_len_out   = prog_len_q;
  assign run_busy_out   = !host_q && (state_q == BCFH_EXEC ||
                                      state_q == BCFH_RUN);

  // ****************************************************************
  // checks
  // ****************************************************************
  quiet_when_idle_a: assert property (
    (state_q == BCFH_IDLE) |-> !tx_valid_out && xcvr_tx_n_out)
    else $error("reply traffic while idle");
  drive_with_tx_a: assert property (
    tx_valid_out |-> !xcvr_tx_n_out)
    else $error("reply byte without transceiver drive");
  exec_then_tx_a: assert property (
    (exec_fin && host_q) |=> tx_valid_out && !exec_req_out)
    else $error("reply not started right after execution");
  no_tx_in_exec_a: assert property (
    exec_req_out |-> !tx_valid_out)
    else $error("reply while command still executing");
  one_reply_a: assert property (
    (tx_fire && tx_is_last) |=> !tx_valid_out [*2])
    else $error("reply continued past final byte");
  serial_order_a: assert property (
    ($rose(tx_valid_out) && !can_mode_in) |->
      tx_data_out == reply_addr_in)
    else $error("serial reply does not open with reply address");
  reply_csum_a: assert property (
    (tx_valid_out && tx_pos_q == BCFH_RPOS_CSUM) |->
      tx_data_out == tx_acc)
    else $error("reply checksum wrong");
  can_reply_a: assert property (
    ($rose(tx_valid_out) && can_mode_in) |->
      tx_data_out == stat_q && can_id_out == reply_addr_in)
    else $error("CAN reply does not open with status");
  bad_csum_a: assert property (
    (state_q == BCFH_IDLE && frame_end && addr_ok && !csum_ok) |=>
      !exec_req_out && stat_q == BCFH_ST_CSUM ##1 !exec_req_out)
    else $error("corrupt frame executed or misreported");
  store_code_a: assert property (
    (state_q == BCFH_STORE && !prog_full) |=>
      stat_q == BCFH_ST_LOADED && prog_len_out == $past(prog_len_q) + 1)
    else $error("store not acknowledged with loaded code");

  serial_reply_c: cover property (
    !can_mode_in && tx_fire && tx_pos_q == BCFH_RPOS_CSUM);
  can_reply_c: cover property (
    can_mode_in && tx_fire && tx_is_last);
  csum_error_c: cover property (
    tx_valid_out && stat_q == BCFH_ST_CSUM);
  standalone_c: cover property (exec_fin && !host_q && run_last);

endmodule
`default_nettype wire

// File: hw/bcfh_pkg.sv
`default_nettype none
// ****************************************************************
// frame layout, reply codes and state encoding
// ****************************************************************
package bcfh_pkg;

  // command frame byte positions (serial numbering)
  localparam logic [3:0] BCFH_POS_ADDR  = 4'h0; // module address
  localparam logic [3:0] BCFH_POS_CMD   = 4'h1; // command number
  localparam logic [3:0] BCFH_POS_TYPE  = 4'h2; // type number
  localparam logic [3:0] BCFH_POS_BANK  = 4'h3; // motor or bank
  localparam logic [3:0] BCFH_POS_VAL0  = 4'h4; // value, msb first
  localparam logic [3:0] BCFH_POS_VAL3  = 4'h7; // value, lsb last
  localparam logic [3:0] BCFH_POS_CSUM  = 4'h8; // checksum

  // reply frame byte positions (serial numbering)
  localparam logic [3:0] BCFH_RPOS_RADDR = 4'h0; // reply address
  localparam logic [3:0] BCFH_RPOS_MADDR = 4'h1; // module address
  localparam logic [3:0] BCFH_RPOS_STAT  = 4'h2; // status
  localparam logic [3:0] BCFH_RPOS_CMD   = 4'h3; // echoed command
  localparam logic [3:0] BCFH_RPOS_VAL0  = 4'h4; // value msb
  localparam logic [3:0] BCFH_RPOS_VAL1  = 4'h5; // value
  localparam logic [3:0] BCFH_RPOS_VAL2  = 4'h6; // value
  localparam logic [3:0] BCFH_RPOS_VAL3  = 4'h7; // value lsb
  localparam logic [3:0] BCFH_RPOS_CSUM  = 4'h8; // checksum

  // reply status codes
  localparam logic [7:0] BCFH_ST_OK       = 8'h64; // executed
  localparam logic [7:0] BCFH_ST_LOADED   = 8'h65; // stored
  localparam logic [7:0] BCFH_ST_CSUM     = 8'h01; // bad checksum
  localparam logic [7:0] BCFH_ST_BADCMD   = 8'h02; // unknown command
  localparam logic [7:0] BCFH_ST_BADTYPE  = 8'h03; // bad type
  localparam logic [7:0] BCFH_ST_BADVAL   = 8'h04; // bad value
  localparam logic [7:0] BCFH_ST_LOCKED   = 8'h05; // config locked
  localparam logic [7:0] BCFH_ST_NOTAVAIL = 8'h06; // unavailable

  // reset values
  localparam logic [7:0]  BCFH_RST_BYTE = 8'h00;        // byte regs
  localparam logic [31:0] BCFH_RST_WORD = 32'h00000000; // value regs

  // frame handler states
  typedef enum logic [2:0] {
    BCFH_IDLE,  // receiving
    BCFH_EXEC,  // command at executor
    BCFH_STORE, // command into program memory
    BCFH_RUN,   // fetch next stored command
    BCFH_TX     // sending reply
  } bcfh_state_t;

endpackage
`default_nettype wire

// File: hw/bcfh_sum.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// modulo-256 additive checksum accumulator
// ****************************************************************
module bcfh_sum
  import bcfh_pkg::*;
(
  input  wire logic       clk_in,   // system clock
  input  wire logic       rst_n_in, // sync reset, low
  input  wire logic       clear_in, // restart sum, wins over add
  input  wire logic       add_in,   // accumulate byte_in
  input  wire logic [7:0] byte_in,  // byte to add
  output logic      [7:0] acc_out,  // sum of bytes so far
  output logic      [7:0] next_out  // sum including byte_in
);

  logic [7:0] acc_q; // running sum

  // carry out of bit 7 is dropped on purpose: 8-bit addition
  assign next_out = acc_q + byte_in;
  assign acc_out  = acc_q;

  // ****************************************************************
  // accumulator
  // ****************************************************************
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in || clear_in)
      acc_q <= BCFH_RST_BYTE;
    else if (add_in)
      acc_q <= next_out;
  end

endmodule
`default_nettype wire

// File: testbench/bcfh_host.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// host master model: frames out, stalls on the reply link
// ****************************************************************
module bcfh_host
(
  input  wire logic       clk_in,       // system clock
  input  wire logic       tx_valid_in,  // reply byte valid
  input  wire logic       tx_last_in,   // final reply byte
  output logic      [7:0] rx_data_out,  // byte to device
  output logic            rx_valid_out, // byte strobe
  output logic            tx_ready_out  // accept reply byte
);
  initial
  begin
    rx_data_out  = 8'h00;
    rx_valid_out = 1'b0;
    tx_ready_out = 1'b1;
  end
  // random stalls, so reply bytes must hold until taken
  initial
    forever
    begin
      @(posedge clk_in);
      #2 tx_ready_out = ($urandom_range(0, 3) != 0);
    end
  // bytes back to back; optional checksum, corrupt on request
  task automatic send(input logic [7:0] b[$], input bit add_sum,
                      input bit bad, input bit want, output bit hung);
    logic [7:0] s;
    s = 8'h00;
    foreach (b[i]) s = s + b[i];
    if (add_sum)
      b.push_back(s + {7'h00, bad});
    foreach (b[i])
    begin
      rx_data_out  = b[i];
      rx_valid_out = 1'b1;
      @(posedge clk_in);
      #2;
    end
    rx_valid_out = 1'b0;
    rx_data_out  = ~rx_data_out; // released line shows no stale byte
    hung = want;
    // next frame only after the whole reply
    repeat (300)
    begin
      if (hung)
      begin
        @(posedge clk_in);
        if (tx_valid_in && tx_ready_out && tx_last_in)
          hung = 1'b0;
      end
    end
    #2;
  endtask
endmodule
`default_nettype wire

// File: testbench/test_binary_command_frame_handler.sv
`timescale 1ns/1ps
`default_nettype none
module test_binary_command_frame_handler;
  import bcfh_pkg::*;
  logic clk_in, rst_n_in, can_m, load_m, clr, run, done, busy, txv, last;
  logic ready, xcvr_n, req, host;
  logic [7:0]  rxd, maddr, raddr, st, txd, cid, ecmd, etyp, ebank, cur_st;
  logic [31:0] eval_o, eval_i, cur_val;
  logic [6:0]  plen;
  logic        rxv;
  logic [8:0]  exp_q[$];  // expected {last, byte}
  logic [56:0] cmd_q[$];  // expected {host, cmd, type, bank, value}
  int fail_count, samples_checked, cyc;
  bit hung;
  // executor status values driven through the reply path
  logic [7:0]  st_list [6] = '{BCFH_ST_OK, BCFH_ST_BADCMD, BCFH_ST_BADTYPE,
                              BCFH_ST_BADVAL, BCFH_ST_LOCKED,
                              BCFH_ST_NOTAVAIL};
  bcfh_core i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .can_mode_in(can_m),
    .module_addr_in(maddr), .reply_addr_in(raddr), .load_mode_in(load_m),
    .prog_clear_in(clr), .run_start_in(run), .rx_data_in(rxd),
    .rx_valid_in(rxv), .exec_req_out(req), .exec_cmd_out(ecmd),
    .exec_type_out(etyp), .exec_bank_out(ebank), .exec_value_out(eval_o),
    .exec_host_out(host), .exec_done_in(done), .exec_status_in(st),
    .exec_value_in(eval_i), .tx_data_out(txd), .tx_valid_out(txv),
    .tx_last_out(last), .tx_ready_in(ready), .xcvr_tx_n_out(xcvr_n),
    .can_id_out(cid), .prog_len_out(plen), .run_busy_out(busy));
  bcfh_host i_host (.clk_in(clk_in), .tx_valid_in(txv), .tx_last_in(last),
    .rx_data_out(rxd), .rx_valid_out(rxv), .tx_ready_out(ready));
  initial
  begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  // generic compare, four-state safe
  task automatic chk(input string what, input logic [63:0] e, g);
    samples_checked++;
    if (e !== g)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  // reply byte compare: {last, byte}
  task automatic chk_reply(input logic [8:0] e, g);
    chk("reply", {55'h0, e}, {55'h0, g});
  endtask
  // executor request compare: {host, cmd, type, bank, value}
  task automatic chk_exec(input logic [56:0] e, g);
    chk("exec", {7'h0, e}, {7'h0, g});
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // cycle ceiling against hangs
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      wrap_up();
    end
  end
  // reply watcher: oldest note against each byte taken
  always @(posedge clk_in)
    if (rst_n_in === 1'b1)
    begin
      chk("xcvr_n", {63'h0, ~txv}, {63'h0, xcvr_n});
      if (txv === 1'b1 && ready === 1'b1)
      begin
        if (exp_q.size() == 0)
          chk("unasked", 64'h0, 64'h1);
        else
          chk_reply(exp_q.pop_front(), {last, txd});
      end
    end
  // executor model: random latency, status from the bench
  initial
  begin
    done = 1'b0;
    st = 8'h00;
    eval_i = 32'h0;
    forever
    begin
      @(posedge clk_in iff req === 1'b1);
      chk_exec(cmd_q.size() ? cmd_q.pop_front() : 57'h0,
               {host, ecmd, etyp, ebank, eval_o});
      repeat ($urandom_range(0, 3)) @(posedge clk_in);
      #2 done = 1'b1;
      st = cur_st;
      eval_i = cur_val;
      @(posedge clk_in);
      #2 done = 1'b0;
      eval_i = ~eval_i;
    end
  end
  // one frame; k: 0 execute, 1 bad checksum, 2 store, 3 other address
  task automatic frame(input int k);
    logic [7:0] b[$], r[$], s, c;
    logic [31:0] v, rv;
    c = 8'($urandom_range(1, 40));
    v = $urandom();
    cur_val = $urandom();
    b = '{c, 8'($urandom()), 8'($urandom()),
          v[31:24], v[23:16], v[15:8], v[7:0]};
    if (!can_m)
      b.push_front(k == 3 ? ~maddr : maddr);
    rv = (k == 0) ? cur_val : (k == 2) ? v : 32'h0;
    s = (k == 0) ? cur_st : (k == 2) ? BCFH_ST_LOADED : BCFH_ST_CSUM;
    r = '{s, c, rv[31:24], rv[23:16], rv[15:8], rv[7:0]};
    if (k == 0)
      cmd_q.push_back({1'b1, b[$-6], b[$-5], b[$-4], v});
    if (!can_m)
    begin
      r.push_front(maddr);
      r.push_front(raddr);
      s = 8'h00;
      foreach (r[i]) s = s + r[i];
      r.push_back(s);
    end
    if (k != 3)
      foreach (r[i]) exp_q.push_back({i == r.size() - 1, r[i]});
    i_host.send(b, !can_m, k == 1, k != 3, hung);
    chk("hang", 64'h0, {63'h0, hung});
    if (k == 2 && !can_m)
      cmd_q.push_back({1'b0, b[1], b[2], b[3], v});
    repeat (20) @(posedge clk_in);
    #2;
  endtask
  initial
  begin
    void'($urandom(62367));
    {rst_n_in, can_m, load_m, clr, run} = 5'h00;
    maddr = 8'($urandom_range(1, 127));
    raddr = 8'($urandom_range(128, 255));
    cur_st = BCFH_ST_OK;
    repeat (2) @(posedge clk_in);
    #2 rst_n_in = 1'b1;
    // every executor status passes through unchanged
    foreach (st_list[i])
    begin
      cur_st = st_list[i];
      frame(0);
    end
    frame(1);
    frame(3);
    // store two commands, then run them without a host
    clr = 1'b1;
    @(posedge clk_in);
    #2 clr = 1'b0;
    load_m = 1'b1;
    frame(2);
    frame(2);
    chk("prog_len", 64'd2, {57'h0, plen});
    load_m = 1'b0;
    run = 1'b1;
    @(posedge clk_in);
    #2 run = 1'b0;
    repeat (200) @(posedge clk_in);
    chk("run_left", 64'h0, {63'h0, busy || cmd_q.size() != 0});
    #2 can_m = 1'b1;
    cur_st = BCFH_ST_OK;
    frame(0);
    chk("can_id", {56'h0, raddr}, {56'h0, cid});
    chk("replies_left", 64'h0, 64'(exp_q.size()));
    wrap_up();
  end
endmodule
`default_nettype wire
